/* File: inc/pin_select_regs.svh */
// Register indices, field positions, reset values of the pin selector
`ifndef PIN_SELECT_REGS_SVH
`define PIN_SELECT_REGS_SVH

// Word indices on the register bus
`define IDX_SYNC1_FAULT8 3'h0
`define IDX_SYNC2 3'h1
`define IDX_PINS_0_1 3'h2
`define IDX_PINS_10_11 3'h7

// Field positions inside a selector word
`define FIELD_LO_LSB 0
`define FIELD_HI_LSB 8
`define FIELD_WIDTH 6

// Reset values, the input grounding code and the output free code
`define INPUT_SEL_RESET 6'h3F
`define OUTPUT_SEL_RESET 6'h00
`define INPUT_GROUND_CODE 6'h3F
`define OUTPUT_FREE_CODE 6'h00

`endif

/* File: inc/pin_select_pkg.sv */
// Types shared by the pin selector design
package pin_select_pkg;
   typedef logic [5:0] sel_code_t;
   typedef logic [31:0] bus_word_t;
   typedef enum logic [1:0]
   {
      BUS_IDLE = 2'b01,
      BUS_ANSWER = 2'b10
   } bus_phase_t;
endpackage : pin_select_pkg

/* File: src/selector_field.sv */
// One six-bit selector field with its own reset value
`timescale 1ns/1ps
module selector_field
#(
   parameter logic [5:0] RESET_VALUE = 6'h00
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [5:0] wr_data,
   output logic [5:0] value
);
   logic [5:0] next_value;

   // Load on a write strobe, otherwise hold
   always_comb
   begin
      next_value = value;
      if (wr_en)
      begin
         next_value = wr_data;
      end
   end

   // Field storage
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         value <= RESET_VALUE;
      end
      else
      begin
         value <= next_value;
      end
   end
endmodule : selector_field

/* File: src/remappable_pin_select.sv */
// Remappable pin selector: input routing, output routing, register slave
`timescale 1ns/1ps
`include "pin_select_regs.svh"
module remappable_pin_select
#(
   parameter int NUM_RP_PINS = 36,
   parameter int NUM_FUNCS = 64,
   parameter bit HAS_PINS_8_11 = 1'b1
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire pin_select_pkg::bus_word_t avs_writedata,
   output pin_select_pkg::bus_word_t avs_readdata,
   output logic avs_waitrequest,
   input wire logic [NUM_RP_PINS-1:0] remappable_pin,
   input wire logic [NUM_FUNCS-1:0] periph_out,
   input wire logic [11:0] gpio_out,
   output logic sync_in1,
   output logic sync_in2,
   output logic pwm_fault_input_8,
   output logic [11:0] pin_out,
   output logic [11:0] pin_periph_owned
);
   import pin_select_pkg::*;

   localparam int NUM_FIELDS = 15;

   // Elaboration checks: six-bit codes reach at most 63 pins or functions
   if (NUM_RP_PINS < 12 || NUM_RP_PINS > 63)
   begin : g_bad_pins
      $error("NUM_RP_PINS must lie between 12 and 63");
   end
   if (NUM_FUNCS < 2 || NUM_FUNCS > 64)
   begin : g_bad_funcs
      $error("NUM_FUNCS must lie between 2 and 64");
   end

   bus_phase_t phase;
   bus_phase_t next_phase;
   bus_word_t next_readdata;
   logic bus_commit;
   logic [NUM_RP_PINS-1:0] pin_meta;
   logic [NUM_RP_PINS-1:0] pin_sync;
   sel_code_t field_value [NUM_FIELDS];
   sel_code_t sync1_sel;
   sel_code_t fault8_sel;
   sel_code_t sync2_sel;
   sel_code_t pin_sel [12];
   logic next_sync_in1;
   logic next_sync_in2;
   logic next_fault8;
   logic [11:0] next_pin_out;
   logic [11:0] next_owned;

   // Field order: sync1, fault8, sync2, then output pins 0 to 11
   assign sync1_sel = field_value[0];
   assign fault8_sel = field_value[1];
   assign sync2_sel = field_value[2];
   for (genvar p = 0; p < 12; p++)
   begin : g_pin_sel
      assign pin_sel[p] = field_value[3 + p];
   end

   // Request is answered one cycle after it is seen, so readdata can be
   // registered; writes commit only on the edge that ends the wait
   always_comb
   begin
      next_phase = BUS_IDLE;
      unique case (phase)
         BUS_IDLE:
         begin
            if (avs_read || avs_write)
            begin
               next_phase = BUS_ANSWER;
            end
         end
         BUS_ANSWER:
         begin
            next_phase = BUS_IDLE;
         end
         default:
         begin
            next_phase = BUS_IDLE;
         end
      endcase
   end

   assign avs_waitrequest = (avs_read || avs_write) && (phase != BUS_ANSWER);
   assign bus_commit = avs_write && (phase == BUS_ANSWER);

   // One storage field per selector; write strobes decoded per lane
   for (genvar k = 0; k < NUM_FIELDS; k++)
   begin : g_field
      localparam logic [2:0] IDX = (k == 0 || k == 1) ? `IDX_SYNC1_FAULT8 :
         (k == 2) ? `IDX_SYNC2 : 3'((k - 3) / 2 + 2);
      localparam bit HI = (k == 0) || (k >= 3 && ((k - 3) % 2) == 1);
      localparam logic [5:0] RST_VAL = (k < 3) ? `INPUT_SEL_RESET :
         `OUTPUT_SEL_RESET;
      localparam bit PRESENT = HAS_PINS_8_11 || k < 11;
      logic wr_en;
      sel_code_t wr_data;
      // Only the six low bits of each lane are kept; bits 7-6 drop here
      assign wr_en = PRESENT && bus_commit && avs_address == IDX &&
         avs_byteenable[HI ? 1 : 0];
      assign wr_data = HI ? avs_writedata[`FIELD_HI_LSB +: `FIELD_WIDTH] :
         avs_writedata[`FIELD_LO_LSB +: `FIELD_WIDTH];
      selector_field #(.RESET_VALUE(RST_VAL)) u_field
      (
         .ref_clk(ref_clk),
         .rst(rst),
         .wr_en(wr_en),
         .wr_data(wr_data),
         .value(field_value[k])
      );
   end

   // Read data; unimplemented bits and unmapped words read zero
   always_comb
   begin
      next_readdata = avs_readdata;
      if (phase == BUS_IDLE && avs_read)
      begin
         next_readdata = 32'h0000_0000;
         unique case (avs_address)
            `IDX_SYNC1_FAULT8:
            begin
               next_readdata[13:8] = sync1_sel;
               next_readdata[5:0] = fault8_sel;
            end
            `IDX_SYNC2:
            begin
               next_readdata[5:0] = sync2_sel;
            end
            default:
            begin
               if (HAS_PINS_8_11 || avs_address < 3'h6)
               begin
                  next_readdata[5:0] = pin_sel[2 * (avs_address - 2)];
                  next_readdata[13:8] = pin_sel[2 * (avs_address - 2) + 1];
               end
            end
         endcase
      end
   end

   // Bus state and read data registers
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         phase <= BUS_IDLE;
         avs_readdata <= 32'h0000_0000;
      end
      else
      begin
         phase <= next_phase;
         avs_readdata <= next_readdata;
      end
   end

   // Pins come from outside the clock domain: two-stage synchroniser
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
      end
      else
      begin
         pin_meta <= remappable_pin;
         pin_sync <= pin_meta;
      end
   end

   // Input routing; codes past the last pin also ground the input
   function automatic logic route_in(sel_code_t code,
      logic [NUM_RP_PINS-1:0] pins);
      logic bit_out;
      bit_out = 1'b0;
      if (code != `INPUT_GROUND_CODE && int'(code) < NUM_RP_PINS)
      begin
         bit_out = pins[code];
      end
      return bit_out;
   endfunction : route_in

   // Output routing: zero hands the pin back to its port function
   always_comb
   begin
      next_sync_in1 = route_in(sync1_sel, pin_sync);
      next_sync_in2 = route_in(sync2_sel, pin_sync);
      next_fault8 = route_in(fault8_sel, pin_sync);
      for (int p = 0; p < 12; p++)
      begin
         next_owned[p] = pin_sel[p] != `OUTPUT_FREE_CODE;
         next_pin_out[p] = gpio_out[p];
         if (next_owned[p] && int'(pin_sel[p]) < NUM_FUNCS)
         begin
            next_pin_out[p] = periph_out[pin_sel[p]];
         end
         else if (next_owned[p])
         begin
            next_pin_out[p] = 1'b0;
         end
      end
   end

   // Routed outputs follow the selectors one edge later
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         sync_in1 <= 1'b0;
         sync_in2 <= 1'b0;
         pwm_fault_input_8 <= 1'b0;
         pin_out <= 12'h000;
         pin_periph_owned <= 12'h000;
      end
      else
      begin
         sync_in1 <= next_sync_in1;
         sync_in2 <= next_sync_in2;
         pwm_fault_input_8 <= next_fault8;
         pin_out <= next_pin_out;
         pin_periph_owned <= next_owned;
      end
   end

   // Marks the first cycle after reset release for checking
   logic first_cycle;
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         first_cycle <= 1'b1;
      end
      else
      begin
         first_cycle <= 1'b0;
      end
   end

   property p_sync1_write;
      @(posedge ref_clk) disable iff (rst)
      (bus_commit && avs_address == 3'h0 && avs_byteenable[1])
      |=> sync1_sel == $past(avs_writedata[13:8]);
   endproperty
   a_sync1_write: assert property (p_sync1_write)
      else $error("sync1 selector did not take the write");

   property p_fault8_write;
      @(posedge ref_clk) disable iff (rst)
      (bus_commit && avs_address == 3'h0 && avs_byteenable[0])
      |=> fault8_sel == $past(avs_writedata[5:0]);
   endproperty
   a_fault8_write: assert property (p_fault8_write)
      else $error("fault8 selector did not take the write");

   property p_sync2_write;
      @(posedge ref_clk) disable iff (rst)
      (bus_commit && avs_address == 3'h1 && avs_byteenable[0])
      |=> sync2_sel == $past(avs_writedata[5:0]);
   endproperty
   a_sync2_write: assert property (p_sync2_write)
      else $error("sync2 selector did not take the write");

   property p_ground;
      @(posedge ref_clk) disable iff (rst)
      (fault8_sel == 6'h3F) [*2] |-> !pwm_fault_input_8;
   endproperty
   a_ground: assert property (p_ground)
      else $error("grounded fault input is not low");

   property p_pin_route;
      @(posedge ref_clk) disable iff (rst)
      (sync1_sel == 6'h00) |=> sync_in1 == $past(pin_sync[0]);
   endproperty
   a_pin_route: assert property (p_pin_route)
      else $error("sync1 does not follow pin zero");

   property p_reset_values;
      @(posedge ref_clk) disable iff (rst)
      first_cycle |-> sync1_sel == 6'h3F && sync2_sel == 6'h3F &&
         fault8_sel == 6'h3F && pin_sel[0] == 6'h00 && pin_sel[11] == 6'h00;
   endproperty
   a_reset_values: assert property (p_reset_values)
      else $error("selector reset values wrong");

   property p_reserved_zero;
      @(posedge ref_clk) disable iff (rst)
      (avs_read && !avs_waitrequest) |-> avs_readdata[31:14] == 18'h0 &&
         avs_readdata[7:6] == 2'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("unimplemented bits read nonzero");

   property p_sync2_upper;
      @(posedge ref_clk) disable iff (rst)
      (avs_read && !avs_waitrequest && avs_address == 3'h1)
      |-> avs_readdata[31:6] == 26'h0;
   endproperty
   a_sync2_upper: assert property (p_sync2_upper)
      else $error("upper bits of sync2 word read nonzero");

   property p_odd_pin_write;
      @(posedge ref_clk) disable iff (rst)
      (bus_commit && avs_address == 3'h2 && avs_byteenable[1])
      |=> pin_sel[1] == $past(avs_writedata[13:8]);
   endproperty
   a_odd_pin_write: assert property (p_odd_pin_write)
      else $error("pin one selector did not take the high field");

   property p_small_part;
      @(posedge ref_clk) disable iff (rst)
      !HAS_PINS_8_11 |-> pin_sel[8] == 6'h00 && pin_sel[11] == 6'h00;
   endproperty
   a_small_part: assert property (p_small_part)
      else $error("absent output selectors changed");

   // The release edge still registers reset-cleared outputs, so skip it
   property p_port_fallback;
      @(posedge ref_clk) disable iff (rst)
      (pin_sel[0] == 6'h00 && !first_cycle)
      |=> pin_out[0] == $past(gpio_out[0]) && !pin_periph_owned[0];
   endproperty
   a_port_fallback: assert property (p_port_fallback)
      else $error("free pin does not show its port value");

   property p_answer_time;
      @(posedge ref_clk) disable iff (rst)
      ((avs_read || avs_write) && phase == BUS_IDLE)
      |-> avs_waitrequest ##1 !avs_waitrequest;
   endproperty
   a_answer_time: assert property (p_answer_time)
      else $error("bus answer not one cycle after request");
endmodule : remappable_pin_select

/* File: verif/pin_partner.sv */
// Model of the pads and peripheral outputs around the pin selector
`timescale 1ns/1ps
module pin_partner
(
   input wire logic ref_clk,
   input wire logic [35:0] next_pins,
   input wire logic [63:0] next_funcs,
   input wire logic [11:0] next_gpio,
   output logic [35:0] pins = '0,
   output logic [63:0] funcs = '0,
   output logic [11:0] gpio = '0
);
   // Pads and peripherals change just after the edge, like real flops
   always @(posedge ref_clk)
   begin
      pins <= next_pins;
      funcs <= next_funcs;
      gpio <= next_gpio;
   end
endmodule : pin_partner

/* File: verif/remappable_pin_select_tb_top.sv */
// Self-checking bench for the remappable pin selector
`timescale 1ns/1ps
module remappable_pin_select_tb_top;
   import pin_select_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] avs_address = 3'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [3:0] avs_byteenable = 4'hF;
   bus_word_t avs_writedata = 32'h0;
   bus_word_t avs_readdata;
   logic avs_waitrequest;
   logic [35:0] pins;
   logic [63:0] funcs;
   logic [11:0] gpios;
   logic sync_in1;
   logic sync_in2;
   logic pwm_fault_input_8;
   logic [11:0] pin_out;
   logic [11:0] pin_periph_owned;
   bus_word_t small_readdata;
   bus_word_t want;
   logic [11:0] small_pin_out;
   logic [11:0] small_owned;
   logic [35:0] pv = 36'h0;
   logic [63:0] fv = 64'h0;
   logic [11:0] gv = 12'h0;
   logic [15:0] shadow [8];
   logic [5:0] codes [6] = '{6'h00, 6'h23, 6'h20, 6'h3F, 6'h24, 6'h11};
   bus_word_t exp_q [$];
   int errors = 0;
   int check_count = 0;
   int seed = 32'h343B2CDC;

   always #10 ref_clk = ~ref_clk;

   pin_partner far (.ref_clk(ref_clk), .next_pins(pv), .next_funcs(fv),
      .next_gpio(gv), .pins(pins), .funcs(funcs), .gpio(gpios));

   remappable_pin_select #(.NUM_RP_PINS(36), .NUM_FUNCS(64),
      .HAS_PINS_8_11(1'b1)) uut (.ref_clk(ref_clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(avs_byteenable),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .remappable_pin(pins),
      .periph_out(funcs), .gpio_out(gpios), .sync_in1(sync_in1),
      .sync_in2(sync_in2), .pwm_fault_input_8(pwm_fault_input_8),
      .pin_out(pin_out), .pin_periph_owned(pin_periph_owned));

   // Smallest family member: words for pins 8 to 11 left out
   remappable_pin_select #(.NUM_RP_PINS(36), .NUM_FUNCS(64),
      .HAS_PINS_8_11(1'b0)) uut_small (.ref_clk(ref_clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(avs_byteenable),
      .avs_writedata(avs_writedata), .avs_readdata(small_readdata),
      .avs_waitrequest(), .remappable_pin(pins),
      .periph_out(funcs), .gpio_out(gpios), .sync_in1(),
      .sync_in2(), .pwm_fault_input_8(),
      .pin_out(small_pin_out), .pin_periph_owned(small_owned));

   task report_and_stop;
      $display("comparisons %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop

   task check(input bus_word_t seen, input bus_word_t want);
      check_count++;
      if (seen !== want)
      begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
            want);
      end
   endtask : check

   // Read answers are compared in order against the driver's notes
   always @(posedge ref_clk)
   begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      begin
         want = exp_q.pop_front();
         check(avs_readdata, want);
         check(small_readdata, (avs_address > 3'h5) ? 32'h0 : want);
      end
   end

   // One bus cycle; held until waitrequest is seen low at an edge
   task bus(input logic rd, input logic [2:0] a, input bus_word_t d,
      input logic [3:0] be);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= rd;
      avs_write <= !rd;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 20);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0)
      begin
         errors++;
         report_and_stop();
      end
   endtask : bus

   // Only enabled lanes and six-bit fields land; word 1 has no high lane
   task wr(input logic [2:0] a, input bus_word_t d, input logic [3:0] be);
      logic [15:0] m;
      m = {(be[1] && a != 3'h1) ? 8'h3F : 8'h00, be[0] ? 8'h3F : 8'h00};
      shadow[a] = (shadow[a] & ~m) | (d[15:0] & m);
      bus(1'b0, a, d, be);
   endtask : wr

   task rd(input logic [2:0] a);
      exp_q.push_back({16'h0000, shadow[a]});
      bus(1'b1, a, 32'h0, 4'hF);
   endtask : rd

   // New random levels on pads and peripheral outputs
   task shake;
      logic [11:0] g;
      g = 12'($random(seed));
      gv <= g;
      pv <= {g[3:0], $random(seed)};
      fv <= {$random(seed), $random(seed)};
   endtask : shake

   function logic insel(input logic [5:0] c);
      return (c < 6'h24) ? pv[c] : 1'b0;
   endfunction : insel

   // Wait out synchroniser and output flop, then compare every route
   task check_routes;
      logic [11:0] po;
      logic [11:0] ow;
      logic [5:0] c;
      repeat (6) @(posedge ref_clk);
      for (int k = 0; k < 12; k++)
      begin
         c = shadow[2 + k / 2][(k % 2) * 8 +: 6];
         ow[k] = (c != 6'h00);
         po[k] = (c == 6'h00) ? gv[k] : fv[c];
      end
      check(pin_out, po);
      check(pin_periph_owned, ow);
      check(small_pin_out, {gv[11:8], po[7:0]});
      check(small_owned, {4'h0, ow[7:0]});
      check(sync_in1, insel(shadow[0][13:8]));
      check(pwm_fault_input_8, insel(shadow[0][5:0]));
      check(sync_in2, insel(shadow[1][5:0]));
   endtask : check_routes

   task reset_state;
      shadow[0] = 16'h3F3F;
      shadow[1] = 16'h003F;
      for (int a = 2; a < 8; a++)
         shadow[a] = 16'h0000;
      for (int a = 0; a < 8; a++)
         rd(3'(a));
      check_routes();
   endtask : reset_state

   // Main sequence
   initial
   begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      shake();
      reset_state();
      $display("test reset values done");
      for (int a = 0; a < 8; a++)
      begin
         wr(3'(a), 32'hFFFFFFFF, 4'hF);
         rd(3'(a));
      end
      $display("test unimplemented bits done");
      for (int i = 0; i < 6; i++)
      begin
         shake();
         wr(3'h0, {16'hFFFF, 2'b11, codes[i], 2'b11, codes[(i + 1) % 6]},
            4'hF);
         wr(3'h1, {16'hFFFF, 8'hFF, 2'b11, codes[(i + 2) % 6]}, 4'h3);
         check_routes();
      end
      $display("test input codes done");
      for (int r = 0; r < 8; r++)
      begin
         shake();
         for (int a = 0; a < 8; a++)
         begin
            wr(3'(a), $random(seed), 4'($random(seed)));
            rd(3'(a));
         end
         check_routes();
      end
      $display("test random routing done");
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      reset_state();
      $display("test second reset done");
      report_and_stop();
   end
endmodule : remappable_pin_select_tb_top
